/* File: design/bwa_alu.sv */
// Byte and word arithmetic and logic datapath with zero, nibble-carry and carry flags.
`timescale 1ns/1ps
`include "bwa_cfg.svh"
module bwa_alu
	import bwa_pkg::*;
#(
	parameter int BYTE_W = `BWA_BYTE_W,
	parameter int WORD_W = `BWA_WORD_W
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire bwa_req_s req,
	output bwa_flags_s flags,
	output logic [15:0] result,
	output logic write_en,
	output logic done
);

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	if (BYTE_W != 8 || WORD_W != 16) begin : g_bad_width
		$error("bwa_alu serves only an 8-bit byte and a 16-bit word");
	end

	// ------------------------------------------------------------
	// Arithmetic core
	// ------------------------------------------------------------
	bwa_state_s st_r;
	bwa_state_s st_nxt;

	// A nibble carry or borrow is the XOR of the operand bit 4s with the result bit 4.
	function automatic logic nib_cross(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] r);
		nib_cross = a[`BWA_NIB_POS] ^ b[`BWA_NIB_POS] ^ r[`BWA_NIB_POS];
	endfunction

	logic [8:0] byte_add;
	logic [8:0] byte_sub;
	logic [16:0] word_add;
	logic [16:0] word_sub;
	logic cin;

	always_comb begin
		cin = 1'b0;
		if (req.op == BWA_OP_ADD_WITH_CARRY_OP || req.op == BWA_OP_SUBTRACT_WITH_BORROW_OP) begin
			cin = st_r.flags.carry_flag;
		end
		byte_add = {1'b0, req.dst[7:0]} + {1'b0, req.src[7:0]} + {8'h00, cin};
		byte_sub = {1'b0, req.dst[7:0]} - {1'b0, req.src[7:0]} - {8'h00, cin};
		word_add = {1'b0, req.dst} + {1'b0, req.src};
		word_sub = {1'b0, req.dst} - {1'b0, req.src};
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.write_en = 1'b0;
		if (req.valid) begin
			st_nxt.done = 1'b1;
			st_nxt.write_en = 1'b1;
			unique case (req.op)
				BWA_OP_ADD, BWA_OP_ADD_WITH_CARRY_OP: begin
					st_nxt.result = {8'h00, byte_add[7:0]};
					st_nxt.flags.carry_flag = byte_add[8];
					st_nxt.flags.nibble_carry_flag = nib_cross(req.dst[7:0], req.src[7:0],
						byte_add[7:0]);
					st_nxt.flags.zero_flag = (byte_add[7:0] == 8'h00);
				end
				BWA_OP_SUB, BWA_OP_SUBTRACT_WITH_BORROW_OP, BWA_OP_CMP: begin
					st_nxt.result = {8'h00, byte_sub[7:0]};
					st_nxt.flags.carry_flag = byte_sub[8];
					st_nxt.flags.nibble_carry_flag = nib_cross(req.dst[7:0], req.src[7:0],
						byte_sub[7:0]);
					st_nxt.flags.zero_flag = (byte_sub[7:0] == 8'h00);
					if (req.op == BWA_OP_CMP) begin
						// The difference is dropped, so result still shows the last stored value.
						st_nxt.result = st_r.result;
						st_nxt.write_en = 1'b0;
					end
				end
				BWA_OP_AND: begin
					st_nxt.result = {8'h00, req.dst[7:0] & req.src[7:0]};
					st_nxt.flags.zero_flag = ((req.dst[7:0] & req.src[7:0]) == 8'h00);
				end
				BWA_OP_OR: begin
					st_nxt.result = {8'h00, req.dst[7:0] | req.src[7:0]};
					st_nxt.flags.zero_flag = ((req.dst[7:0] | req.src[7:0]) == 8'h00);
				end
				BWA_OP_XOR: begin
					// An all-ones source inverts the destination.
					st_nxt.result = {8'h00, req.dst[7:0] ^ req.src[7:0]};
					st_nxt.flags.zero_flag = ((req.dst[7:0] ^ req.src[7:0]) == 8'h00);
				end
				BWA_OP_WADD: begin
					st_nxt.result = word_add[15:0];
					st_nxt.flags.carry_flag = word_add[16];
					st_nxt.flags.zero_flag = (word_add[15:0] == 16'h0000);
					// Nibble carry is undefined here; it is simply cleared.
					st_nxt.flags.nibble_carry_flag = 1'b0;
				end
				BWA_OP_WSUB: begin
					st_nxt.result = word_sub[15:0];
					st_nxt.flags.carry_flag = word_sub[16];
					st_nxt.flags.zero_flag = (word_sub[15:0] == 16'h0000);
					st_nxt.flags.nibble_carry_flag = 1'b0;
				end
				default: begin
					// An unused code is refused: nothing written, flags kept.
					st_nxt.done = 1'b0;
					st_nxt.write_en = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_r <= '{done: 1'b0, write_en: 1'b0, result: `BWA_RESULT_RST,
				flags: `BWA_FLAGS_RST};
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign flags = st_r.flags;
	assign result = st_r.result;
	assign write_en = st_r.write_en;
	assign done = st_r.done;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_issue(bwa_op_e o);
		clk_en && req.valid && req.op == o;
	endsequence

	// Codes outside the table are refused; the checks share one view of them.
	function automatic logic op_is_legal(input bwa_op_e o);
		op_is_legal = o inside {BWA_OP_ADD, BWA_OP_ADD_WITH_CARRY_OP, BWA_OP_SUB, BWA_OP_SUBTRACT_WITH_BORROW_OP, BWA_OP_AND,
			BWA_OP_OR, BWA_OP_XOR, BWA_OP_CMP, BWA_OP_WADD, BWA_OP_WSUB};
	endfunction

	sequence s_legal;
		clk_en && req.valid && op_is_legal(req.op);
	endsequence

	sequence s_illegal;
		clk_en && req.valid && !op_is_legal(req.op);
	endsequence

	sequence s_sub_store;
		clk_en && req.valid && (req.op == BWA_OP_SUB || req.op == BWA_OP_SUBTRACT_WITH_BORROW_OP);
	endsequence

	sequence s_logic;
		clk_en && req.valid && (req.op == BWA_OP_AND || req.op == BWA_OP_OR
			|| req.op == BWA_OP_XOR);
	endsequence

	sequence s_byte_store;
		clk_en && req.valid && !(req.op inside {BWA_OP_CMP, BWA_OP_WADD, BWA_OP_WSUB})
			&& op_is_legal(req.op);
	endsequence

	AST_ADD_SUM: assert property (s_issue(BWA_OP_ADD) |=>
		{flags.carry_flag, result[7:0]} == ($past(req.dst[7:0]) + $past(req.src[7:0])) && write_en)
		else $error("byte add result or carry wrong");
	AST_ADD_ZERO: assert property ((clk_en && req.valid && (req.op == BWA_OP_ADD
		|| req.op == BWA_OP_ADD_WITH_CARRY_OP)) |=> flags.zero_flag == (result[7:0] == 8'h00))
		else $error("zero flag after addition wrong");
	AST_ADD_WITH_CARRY_OP_CIN: assert property (s_issue(BWA_OP_ADD_WITH_CARRY_OP) ##0 flags.carry_flag |=>
		result[7:0] == 8'($past(req.dst[7:0]) + $past(req.src[7:0]) + 8'h01))
		else $error("add with carry ignored carry");
	AST_NIB_ADD: assert property (s_issue(BWA_OP_ADD) ##0 (req.dst[3:0] + req.src[3:0] > 5'h0f)
		|=> flags.nibble_carry_flag)
		else $error("nibble carry missed on add");
	AST_SUB_BORROW: assert property (s_issue(BWA_OP_SUB) ##0 (req.dst[7:0] < req.src[7:0])
		|=> flags.carry_flag && !flags.zero_flag)
		else $error("borrow not flagged on subtract");
	AST_SUB_SAME: assert property (s_issue(BWA_OP_SUB) ##0 (req.dst[7:0] == req.src[7:0])
		|=> result[7:0] == 8'h00 && flags.zero_flag && !flags.carry_flag)
		else $error("equal operands did not clear destination");
	AST_SUBTRACT_WITH_BORROW_OP_BORROW: assert property (s_issue(BWA_OP_SUBTRACT_WITH_BORROW_OP) ##0 flags.carry_flag |=>
		result[7:0] == 8'($past(req.dst[7:0]) - $past(req.src[7:0]) - 8'h01))
		else $error("subtract with borrow ignored carry");
	AST_NIB_SUB: assert property (s_issue(BWA_OP_SUB) ##0 (req.dst[3:0] < req.src[3:0])
		|=> flags.nibble_carry_flag)
		else $error("nibble borrow missed on subtract");
	AST_LOGIC_KEEP: assert property (clk_en && req.valid && (req.op == BWA_OP_AND
		|| req.op == BWA_OP_OR || req.op == BWA_OP_XOR) |=>
		$stable({flags.carry_flag, flags.nibble_carry_flag}) && write_en)
		else $error("logical op touched carry flags");
	AST_XOR_INV: assert property (s_issue(BWA_OP_XOR) ##0 (req.src[7:0] == 8'hff) |=>
		result[7:0] == ~$past(req.dst[7:0]))
		else $error("xor with all ones did not invert");
	AST_CMP_NOWRITE: assert property (s_issue(BWA_OP_CMP) |=> !write_en && done
		&& flags.zero_flag == ($past(req.dst[7:0]) == $past(req.src[7:0])))
		else $error("compare wrote or zero flag wrong");
	AST_WADD: assert property (s_issue(BWA_OP_WADD) |=>
		{flags.carry_flag, result} == ({1'b0, $past(req.dst)} + {1'b0, $past(req.src)}))
		else $error("word add sum or carry wrong");
	AST_WSUB: assert property (s_issue(BWA_OP_WSUB) ##0 (req.dst < req.src) |=>
		flags.carry_flag && result == 16'($past(req.dst) - $past(req.src)))
		else $error("word subtract borrow wrong");
	AST_FREEZE: assert property (!clk_en |=> $stable(st_r))
		else $error("state moved while clock enable low");

	// ------------------------------------------------------------
	// Further addition checks
	// ------------------------------------------------------------
	// Add-with-carry reads the held carry, so its nine-bit outcome is held
	// against the carry of the cycle before.
	AST_ADD_WITH_CARRY_OP_SUM: assert property (s_issue(BWA_OP_ADD_WITH_CARRY_OP) |=>
		{flags.carry_flag, result[7:0]} == 9'($past(req.dst[7:0])) + 9'($past(req.src[7:0]))
		+ 9'($past(flags.carry_flag)))
		else $error("add with carry sum or carry wrong");

	AST_ADD_NOCARRY: assert property (s_issue(BWA_OP_ADD) ##0
		(9'(req.dst[7:0]) + 9'(req.src[7:0]) < 9'h100) |=> !flags.carry_flag)
		else $error("carry left set after byte add");

	AST_NIB_ADD_CLEAR: assert property (s_issue(BWA_OP_ADD) ##0
		(5'(req.dst[3:0]) + 5'(req.src[3:0]) < 5'h10) |=> !flags.nibble_carry_flag)
		else $error("nibble carry left set after byte add");

	AST_NIB_ADD_WITH_CARRY_OP: assert property (s_issue(BWA_OP_ADD_WITH_CARRY_OP) |=>
		flags.nibble_carry_flag == (5'($past(req.dst[3:0])) + 5'($past(req.src[3:0]))
		+ 5'($past(flags.carry_flag)) > 5'h0f))
		else $error("nibble carry wrong on add with carry");

	// ------------------------------------------------------------
	// Further subtraction and compare checks
	// ------------------------------------------------------------
	AST_SUB_DIFF: assert property (s_issue(BWA_OP_SUB) |=>
		{flags.carry_flag, result[7:0]} == 9'($past(req.dst[7:0])) - 9'($past(req.src[7:0])))
		else $error("byte subtract difference or borrow wrong");

	AST_SUBTRACT_WITH_BORROW_OP_DIFF: assert property (s_issue(BWA_OP_SUBTRACT_WITH_BORROW_OP) |=>
		{flags.carry_flag, result[7:0]} == 9'($past(req.dst[7:0])) - 9'($past(req.src[7:0]))
		- 9'($past(flags.carry_flag)))
		else $error("subtract with borrow difference or borrow wrong");

	AST_SUB_NOBORROW: assert property (s_issue(BWA_OP_SUB) ##0
		(req.dst[7:0] >= req.src[7:0]) |=> !flags.carry_flag)
		else $error("borrow left set after byte subtract");

	AST_NIB_SUB_CLEAR: assert property (s_issue(BWA_OP_SUB) ##0
		(req.dst[3:0] >= req.src[3:0]) |=> !flags.nibble_carry_flag)
		else $error("nibble borrow left set after byte subtract");

	AST_NIB_SUBTRACT_WITH_BORROW_OP: assert property (s_issue(BWA_OP_SUBTRACT_WITH_BORROW_OP) |=>
		flags.nibble_carry_flag == (5'($past(req.dst[3:0]))
		< 5'($past(req.src[3:0])) + 5'($past(flags.carry_flag))))
		else $error("nibble borrow wrong on subtract with borrow");

	AST_SUB_ZERO: assert property (s_sub_store |=>
		flags.zero_flag == (result[7:0] == 8'h00))
		else $error("zero flag after subtraction wrong");

	AST_SUB_WRITE: assert property (s_sub_store |=> done && write_en)
		else $error("byte subtraction did not write back");

	AST_CMP_FLAGS: assert property (s_issue(BWA_OP_CMP) |=>
		flags.carry_flag == ($past(req.dst[7:0]) < $past(req.src[7:0]))
		&& flags.nibble_carry_flag == ($past(req.dst[3:0]) < $past(req.src[3:0])))
		else $error("compare borrow flags wrong");

	AST_CMP_HOLD: assert property (s_issue(BWA_OP_CMP) |=> $stable(result))
		else $error("compare changed the held result");

	// ------------------------------------------------------------
	// Further logical checks
	// ------------------------------------------------------------
	AST_AND_VAL: assert property (s_issue(BWA_OP_AND) |=>
		result[7:0] == ($past(req.dst[7:0]) & $past(req.src[7:0])) && write_en)
		else $error("logical product wrong");

	AST_OR_VAL: assert property (s_issue(BWA_OP_OR) |=>
		result[7:0] == ($past(req.dst[7:0]) | $past(req.src[7:0])) && write_en)
		else $error("logical sum wrong");

	AST_XOR_VAL: assert property (s_issue(BWA_OP_XOR) |=>
		result[7:0] == ($past(req.dst[7:0]) ^ $past(req.src[7:0])) && write_en)
		else $error("exclusive or wrong");

	AST_LOGIC_ZERO: assert property (s_logic |=>
		flags.zero_flag == (result[7:0] == 8'h00))
		else $error("zero flag after logical op wrong");

	// ------------------------------------------------------------
	// Further word checks
	// ------------------------------------------------------------
	AST_WADD_ZERO: assert property (s_issue(BWA_OP_WADD) |=>
		flags.zero_flag == (result == 16'h0000) && write_en && done)
		else $error("zero flag after word add wrong");

	AST_WSUB_DIFF: assert property (s_issue(BWA_OP_WSUB) |=>
		{flags.carry_flag, result} == 17'($past(req.dst)) - 17'($past(req.src))
		&& write_en)
		else $error("word subtract difference or borrow wrong");

	AST_WSUB_NOBORROW: assert property (s_issue(BWA_OP_WSUB) ##0
		(req.dst >= req.src) |=> !flags.carry_flag)
		else $error("borrow left set after word subtract");

	// ------------------------------------------------------------
	// Completion, refusal and reset checks
	// ------------------------------------------------------------
	AST_BYTE_HIGH: assert property (s_byte_store |=> result[15:8] == 8'h00)
		else $error("byte result left upper byte set");

	AST_LEGAL_DONE: assert property (s_legal |=> done)
		else $error("legal operation gave no completion");

	// A refused code must look like an idle cycle to the sequencer.
	AST_ILLEGAL_REFUSED: assert property (s_illegal |=>
		!done && !write_en && $stable(flags) && $stable(result))
		else $error("refused code changed state");

	AST_IDLE_QUIET: assert property ((clk_en && !req.valid) |=>
		!done && !write_en && $stable(flags) && $stable(result))
		else $error("idle cycle changed state");

	// This one must run while reset is low, so it drops the default disable.
	AST_RESET_CLEAR: assert property (disable iff (1'b0) !rst_n |=>
		!done && !write_en && result == `BWA_RESULT_RST && flags == `BWA_FLAGS_RST)
		else $error("reset did not clear the state");

endmodule

/* File: include/bwa_cfg.svh */
// Constants of the byte and word arithmetic datapath.
`ifndef BWA_CFG_SVH
`define BWA_CFG_SVH
`define BWA_BYTE_W 8
`define BWA_WORD_W 16
`define BWA_NIB_POS 4
`define BWA_FLAG_Z_POS 2
`define BWA_FLAG_AC_POS 1
`define BWA_FLAG_CY_POS 0
`define BWA_FLAGS_RST 3'h0
`define BWA_RESULT_RST 16'h0000
`define BWA_LATENCY 1
`endif

/* File: include/bwa_pkg.sv */
// Types of the byte and word arithmetic datapath.
package bwa_pkg;
	typedef enum logic [3:0] {
		BWA_OP_ADD = 4'h0,
		BWA_OP_ADD_WITH_CARRY_OP = 4'h1,
		BWA_OP_SUB = 4'h3,
		BWA_OP_SUBTRACT_WITH_BORROW_OP = 4'h2,
		BWA_OP_AND = 4'h6,
		BWA_OP_OR = 4'h7,
		BWA_OP_XOR = 4'h5,
		BWA_OP_CMP = 4'h4,
		BWA_OP_WADD = 4'hc,
		BWA_OP_WSUB = 4'hd
	} bwa_op_e;

	typedef struct packed {
		logic zero_flag;
		logic nibble_carry_flag;
		logic carry_flag;
	} bwa_flags_s;

	typedef struct packed {
		logic valid;
		bwa_op_e op;
		logic [15:0] dst;
		logic [15:0] src;
	} bwa_req_s;

	typedef struct packed {
		logic done;
		logic write_en;
		logic [15:0] result;
		bwa_flags_s flags;
	} bwa_state_s;
endpackage

/* File: verif/bwa_alu_bench.sv */
// Self-checking bench of the arithmetic datapath.
`timescale 1ns/1ps
module bwa_alu_bench;
	import bwa_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic issue = 1'b0;
	bwa_op_e op = BWA_OP_ADD;
	logic [15:0] dst = 16'h0;
	logic [15:0] src = 16'h0;
	bwa_req_s req;
	bwa_flags_s flags;
	logic [15:0] result;
	logic write_en;
	logic done;
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;
	always #10 ref_clk = ~ref_clk;
	bwa_seq_model seq (.ref_clk(ref_clk), .rst_n(rst_n), .issue(issue), .op(op),
		.dst(dst), .src(src), .req(req));
	bwa_alu DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
		.flags(flags), .result(result), .write_en(write_en), .done(done));
	task automatic end_sim();
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Flags in {zero, nibble, carry} order; the mask hides undefined bits.
	task automatic run(input bwa_op_e o, input logic [15:0] d, input logic [15:0] s,
		input logic [15:0] xr, input logic [2:0] xf, input logic [2:0] m);
		int n;
		@(posedge ref_clk);
		issue <= 1'b1;
		op <= o;
		dst <= d;
		src <= s;
		@(posedge ref_clk);
		issue <= 1'b0;
		for (n = 0; n < 4 && done !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		check({15'h0, done}, 16'h1);
		check({15'h0, write_en}, {15'h0, o != BWA_OP_CMP});
		if (o != BWA_OP_CMP) begin
			check(result, xr);
		end
		check({13'h0, flags & m}, {13'h0, xf});
	endtask
	task automatic t_add();
		run(BWA_OP_ADD, 16'h0f, 16'h01, 16'h10, 3'h2, 3'h7);
		run(BWA_OP_ADD, 16'hff, 16'h01, 16'h0, 3'h7, 3'h7);
	endtask
	task automatic t_add_with_carry_op();
		run(BWA_OP_ADD, 16'h80, 16'h80, 16'h0, 3'h5, 3'h7);
		run(BWA_OP_ADD_WITH_CARRY_OP, 16'h0e, 16'h01, 16'h10, 3'h2, 3'h7);
	endtask
	task automatic t_sub();
		run(BWA_OP_SUB, 16'h55, 16'h55, 16'h0, 3'h4, 3'h7);
		run(BWA_OP_SUB, 16'h10, 16'h01, 16'h0f, 3'h2, 3'h7);
		run(BWA_OP_SUB, 16'h00, 16'h01, 16'hff, 3'h3, 3'h7);
	endtask
	task automatic t_subtract_with_borrow_op();
		run(BWA_OP_SUBTRACT_WITH_BORROW_OP, 16'h05, 16'h04, 16'h0, 3'h4, 3'h7);
	endtask
	task automatic t_logic();
		run(BWA_OP_SUB, 16'h00, 16'h01, 16'hff, 3'h3, 3'h7);
		run(BWA_OP_AND, 16'hf0, 16'h0f, 16'h0, 3'h7, 3'h7);
		run(BWA_OP_OR, 16'ha0, 16'h05, 16'ha5, 3'h3, 3'h7);
		run(BWA_OP_XOR, 16'h5a, 16'hff, 16'ha5, 3'h3, 3'h7);
	endtask
	task automatic t_cmp();
		run(BWA_OP_CMP, 16'h20, 16'h21, 16'h0, 3'h3, 3'h7);
		run(BWA_OP_CMP, 16'h33, 16'h33, 16'h0, 3'h4, 3'h7);
	endtask
	task automatic t_word();
		run(BWA_OP_WADD, 16'hffff, 16'h1, 16'h0, 3'h5, 3'h5);
		run(BWA_OP_WSUB, 16'h0, 16'h1, 16'hffff, 3'h1, 3'h5);
	endtask
	// An unused code must give no completion and keep result and flags.
	task automatic t_refuse();
		@(posedge ref_clk);
		issue <= 1'b1;
		op <= bwa_op_e'(4'h8);
		dst <= 16'h0001;
		src <= 16'h0001;
		@(posedge ref_clk);
		issue <= 1'b0;
		@(posedge ref_clk);
		#1;
		check({15'h0, done}, 16'h0);
		check(result, 16'hffff);
		check({13'h0, flags & 3'h5}, 16'h1);
	endtask
	task automatic t_reset();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		check(result, 16'h0);
		check({13'h0, flags}, 16'h0);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		run(BWA_OP_ADD_WITH_CARRY_OP, 16'h01, 16'h01, 16'h02, 3'h0, 3'h7);
	endtask
	task automatic t_freeze();
		@(posedge ref_clk);
		clk_en <= 1'b0;
		issue <= 1'b1;
		op <= BWA_OP_ADD;
		dst <= 16'h0001;
		src <= 16'h0001;
		@(posedge ref_clk);
		issue <= 1'b0;
		@(posedge ref_clk);
		#1;
		check({15'h0, done}, 16'h0);
		check({15'h0, write_en}, 16'h0);
		check(result, 16'h0002);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		run(BWA_OP_ADD, 16'h03, 16'h04, 16'h07, 3'h0, 3'h7);
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_add();
		t_add_with_carry_op();
		t_sub();
		t_subtract_with_borrow_op();
		t_logic();
		t_cmp();
		t_word();
		t_refuse();
		t_reset();
		t_freeze();
		end_sim();
	end
endmodule

/* File: verif/bwa_seq_model.sv */
// Sequencer model that turns bench commands into registered requests.
`timescale 1ns/1ps
module bwa_seq_model
	import bwa_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic issue,
	input wire bwa_op_e op,
	input wire logic [15:0] dst,
	input wire logic [15:0] src,
	output bwa_req_s req
);
	// Idle operands toggle, so a design that ignores valid sees junk.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			req <= '0;
		end else begin
			req.valid <= issue;
			req.op <= op;
			req.dst <= issue ? dst : ~req.dst;
			req.src <= issue ? src : ~req.src;
		end
	end
endmodule
